// [dv/fra_accel_props.sv]
// Purpose: Port-level properties of the flash read accelerator
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached to every fra_accel by the bind below
`timescale 1ns/1ps
`include "fra_map.svh"
module fra_accel_props (
    input wire logic                     clk_in,
    input wire logic                     rst_n_in,
    input wire logic                     pref_enable_in,
    input wire logic                     dcache_enable_in,
    input wire logic [`FRA_WAIT_W-1:0]   flash_wait_count_in,
    input wire logic [`FRA_THRESH_W-1:0] ce_threshold_in,
    input wire logic                     ce_clear_in,
    input wire fra_pkg::fra_req_type     ifetch_req_in,
    input wire fra_pkg::fra_rsp_type     ifetch_rsp_out,
    input wire fra_pkg::fra_req_type     dread_req_in,
    input wire fra_pkg::fra_rsp_type     dread_rsp_out,
    input wire fra_pkg::fra_line_type    flash_line_addr_out,
    input wire logic                     flash_read_out,
    input wire fra_pkg::fra_flash_line_type flash_line_in,
    input wire logic                     ue_nmi_out,
    input wire logic                     ce_int_out,
    input wire logic [`FRA_THRESH_W-1:0] ce_count_out
);
    import fra_pkg::*;
    logic [4:0] rd_cnt;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Length of the current flash address hold
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !flash_read_out) begin
            rd_cnt <= 5'h0;
        end else begin
            rd_cnt <= rd_cnt + 5'h1;
        end
    end
    sequence s_i_taken;
        ifetch_req_in.valid && !ifetch_rsp_out.ready && !$past(ifetch_rsp_out.ready);
    endsequence
    sequence s_d_taken;
        dread_req_in.valid && !dread_rsp_out.ready && !$past(dread_rsp_out.ready);
    endsequence
    property p_i_answer; s_i_taken |-> ##[0:60] ifetch_rsp_out.ready; endproperty
    property p_d_answer; s_d_taken |-> ##[0:60] dread_rsp_out.ready; endproperty
    property p_i_pulse; ifetch_rsp_out.ready |=> !ifetch_rsp_out.ready; endproperty
    property p_d_pulse; dread_rsp_out.ready |=> !dread_rsp_out.ready; endproperty
    property p_wait_len;
        $fell(flash_read_out) |-> rd_cnt == {1'b0, flash_wait_count_in} + 5'h1;
    endproperty
    property p_addr_hold;
        flash_read_out && $past(flash_read_out) |-> $stable(flash_line_addr_out);
    endproperty
    property p_nmi_sticky; ue_nmi_out |=> ue_nmi_out; endproperty
    property p_nmi_cause;
        $rose(ue_nmi_out) |-> $past(flash_read_out) || $past(flash_read_out, 2);
    endproperty
    property p_ce_step;
        ce_count_out != $past(ce_count_out) |->
            ce_count_out == $past(ce_count_out) + 16'h1 || ce_count_out == 16'h0;
    endproperty
    property p_ce_int; $rose(ce_int_out) |-> ce_count_out >= $past(ce_threshold_in); endproperty
    a_i_answer: assert property (p_i_answer) else $error("fetch not answered");
    a_d_answer: assert property (p_d_answer) else $error("data read not answered");
    a_i_pulse: assert property (p_i_pulse) else $error("fetch ready too long");
    a_d_pulse: assert property (p_d_pulse) else $error("data ready too long");
    a_wait_len: assert property (p_wait_len) else $error("wrong wait length");
    a_addr_hold: assert property (p_addr_hold) else $error("flash address moved");
    a_nmi_sticky: assert property (p_nmi_sticky) else $error("nmi dropped");
    a_nmi_cause: assert property (p_nmi_cause) else $error("nmi without access");
    a_ce_step: assert property (p_ce_step) else $error("bad count step");
    a_ce_int: assert property (p_ce_int) else $error("interrupt below threshold");
endmodule
bind fra_accel fra_accel_props u_props (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .pref_enable_in(pref_enable_in), .dcache_enable_in(dcache_enable_in),
    .flash_wait_count_in(flash_wait_count_in), .ce_threshold_in(ce_threshold_in),
    .ce_clear_in(ce_clear_in), .ifetch_req_in(ifetch_req_in), .ifetch_rsp_out(ifetch_rsp_out),
    .dread_req_in(dread_req_in), .dread_rsp_out(dread_rsp_out),
    .flash_line_addr_out(flash_line_addr_out), .flash_read_out(flash_read_out),
    .flash_line_in(flash_line_in), .ue_nmi_out(ue_nmi_out), .ce_int_out(ce_int_out),
    .ce_count_out(ce_count_out));

// [dv/fra_accel_tb_top.sv]
// Purpose: Self-checking bench of the flash read accelerator
// Assumes: Wait count 2; flash model on the array side
// Notes:   Latency counted in edges from request to ready
`timescale 1ns/1ps
`include "fra_map.svh"
`define CHK(what, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", what, exp, got); end end
module fra_accel_tb_top;
    import fra_pkg::*;
    localparam int W = 2;
    logic                     clk_in, rst_n_in, pref_en, dc_en, ce_clear, err1, err2;
    logic [`FRA_WAIT_W-1:0]   wait_cnt;
    logic [`FRA_THRESH_W-1:0] thresh, ce_count;
    fra_req_type              ireq, dreq;
    fra_rsp_type              irsp, drsp;
    fra_line_type             faddr;
    fra_flash_line_type       fline;
    logic                     fread, ue_nmi, ce_int;
    int                       n_fail, n_checks;
    fra_accel dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .pref_enable_in(pref_en),
        .dcache_enable_in(dc_en), .flash_wait_count_in(wait_cnt), .ce_threshold_in(thresh),
        .ce_clear_in(ce_clear), .ifetch_req_in(ireq), .ifetch_rsp_out(irsp),
        .dread_req_in(dreq), .dread_rsp_out(drsp), .flash_line_addr_out(faddr),
        .flash_read_out(fread), .flash_line_in(fline), .ue_nmi_out(ue_nmi),
        .ce_int_out(ce_int), .ce_count_out(ce_count));
    fra_flash_model u_flash (.read_in(fread), .line_addr_in(faddr), .err1_in(err1),
        .err2_in(err2), .line_out(fline));
    task automatic complete_run;
        $display("Counts: checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One read; exp_lat 0 skips latency, -1 means more than one cycle
    task automatic rd(input logic is_data, input fra_addr_type a, input int exp_lat);
        int n;
        logic got;
        n = 0;
        got = 1'b0;
        @(posedge clk_in);
        if (is_data) dreq <= '{1'b1, a}; else ireq <= '{1'b1, a};
        while (n < 100 && !got) begin
            @(posedge clk_in);
            #1;
            n++;
            got = ((is_data ? drsp.ready : irsp.ready) === 1'b1);
        end
        if (!got) begin
            n_fail++;
            $display("[FAIL] ready exp 1 got timeout");
            complete_run();
        end
        if (exp_lat > 0) `CHK("latency", exp_lat, n)
        if (exp_lat < 0) `CHK("latency over one", 1'b1, n > 1)
        `CHK("read data", fra_word_type'(a[15:0]), is_data ? drsp.data : irsp.data)
        @(posedge clk_in);
        if (is_data) dreq.valid <= 1'b0; else ireq.valid <= 1'b0;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        $display("[FAIL] run exp end got timeout");
        complete_run();
    end
    initial begin
        n_fail = 0;
        n_checks = 0;
        rst_n_in = 1'b0;
        pref_en = 1'b0;
        dc_en = 1'b0;
        ce_clear = 1'b0;
        err1 = 1'b0;
        err2 = 1'b0;
        wait_cnt = W;
        thresh = 16'h2;
        ireq = '0;
        dreq = '0;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        `CHK("nmi after reset", 1'b0, ue_nmi)
        `CHK("count after reset", 16'h0, ce_count)
        rd(0, 22'h00_0100, W + 3);
        rd(0, 22'h00_0101, W + 3);
        $display("test prefetch_off done");
        @(posedge clk_in) pref_en <= 1'b1;
        repeat (20) @(posedge clk_in);
        rd(0, 22'h00_0200, W + 3);
        repeat (20) @(posedge clk_in);
        for (int i = 1; i < 8; i++) rd(0, 22'h00_0200 + i, 1);
        rd(0, 22'h00_0208, 1);
        repeat (20) @(posedge clk_in);
        rd(0, 22'h00_0210, 1);
        repeat (20) @(posedge clk_in);
        rd(0, 22'h00_0218, 1);
        rd(0, 22'h00_3005, -1);
        repeat (20) @(posedge clk_in);
        rd(0, 22'h00_3006, 1);
        rd(0, 22'h00_3008, 1);
        $display("test prefetch_on done");
        @(posedge clk_in) pref_en <= 1'b0;
        dc_en <= 1'b1;
        repeat (20) @(posedge clk_in);
        rd(1, 22'h00_0400, W + 3);
        rd(1, 22'h00_0407, 1);
        rd(1, 22'h00_0403, 1);
        rd(1, 22'h00_0808, W + 3);
        rd(1, 22'h00_0401, W + 3);
        @(posedge clk_in) dc_en <= 1'b0;
        rd(1, 22'h00_0401, W + 3);
        rd(1, 22'h00_0401, W + 3);
        $display("test data_cache done");
        @(posedge clk_in) err1 <= 1'b1;
        rd(1, 22'h00_0520, W + 3);
        `CHK("count", 16'h1, ce_count)
        `CHK("ce interrupt", 1'b0, ce_int)
        rd(1, 22'h00_0524, W + 3);
        `CHK("ce interrupt", 1'b1, ce_int)
        @(posedge clk_in) ce_clear <= 1'b1;
        @(posedge clk_in) ce_clear <= 1'b0;
        @(posedge clk_in);
        #1;
        `CHK("count cleared", 16'h0, ce_count)
        `CHK("ce interrupt cleared", 1'b0, ce_int)
        @(posedge clk_in) err2 <= 1'b1;
        rd(1, 22'h00_0533, 0);
        repeat (2) @(posedge clk_in);
        #1;
        `CHK("nmi", 1'b1, ue_nmi)
        `CHK("count on double", 16'h0, ce_count)
        $display("test ecc done");
        complete_run();
    end
endmodule

// [dv/fra_flash_model.sv]
// Purpose: Flash array model with per-half check bytes
// Assumes: Word n of line L holds {L[12:0], n}
// Notes:   Lines show inverted data while read_in is low
`timescale 1ns/1ps
module fra_flash_model (
    input  wire logic                    read_in,
    input  wire fra_pkg::fra_line_type   line_addr_in,
    input  wire logic                    err1_in,
    input  wire logic                    err2_in,
    output fra_pkg::fra_flash_line_type  line_out
);
    import fra_pkg::*;
    function automatic logic [7:0] ecc_of(input logic [63:0] d);
        logic [7:0] c;
        int         k;
        c = 8'h0;
        k = 0;
        for (int p = 1; p < 72; p++) begin
            if ((p & (p - 1)) != 0) begin
                for (int i = 0; i < 7; i++) begin
                    if (((p >> i) & 1) != 0) c[i] ^= d[k];
                end
                k++;
            end
        end
        c[7] = ^d ^ ^c[6:0];
        return c;
    endfunction
    always_comb begin
        fra_flash_line_type l;
        l = '0;
        for (int n = 0; n < 8; n++) l.data[16*n+:16] = {line_addr_in[12:0], 3'(n)};
        l.ecc[0] = ecc_of(l.data[63:0]);
        l.ecc[1] = ecc_of(l.data[127:64]);
        // Both flips together make a double error
        if (err1_in) l.data[5] = ~l.data[5];
        if (err2_in) l.data[9] = ~l.data[9];
        line_out = read_in ? l : ~l;
    end
endmodule

// [verilog/fra_accel.sv]
// Purpose: Flash read accelerator: prefetch buffer, data cache, wait states, SECDED
// Assumes: Flash array answers combinationally while the address is held
// Notes:   One flash access at a time; data reads take priority over prefetch
//
// Functional notes
// [RL1] Prefetch enable input; disabled means every fetch pays full wait states.
// [RL2] Look ahead on sequential aligned 128-bit lines from last fetch address.
// [RL3] Two 128-bit buffer entries hold sixteen 16-bit instruction words.
// [RL4] Free entries refill in background while the CPU consumes buffered words.
// [RL5] Buffer hits answer with zero wait states; only discontinuities wait.
// [RL6] Software sets wait count to ceil(cpu/flash frequency) minus one.
// [RL7] Data cache on the data read path, enabled by an input.
// [RL8] Data read with cache enabled captures the whole aligned 128-bit line.
// [RL9] Reads to other words in the cached line answer without wait states.
// [RL10] A data cache miss discards the line and refills with the new one.
// [RL11] Each 64-bit half carries SECDED code: fix single, detect double errors.
// [RL12] ECC check and correction happen before data enters buffer or cache.
// [RL13] Uncorrectable error raises the non-maskable interrupt output.
// [RL14] Corrected errors count to a threshold, then raise maskable interrupt.
// [RL15] Discontinuity invalidates buffer, restarts look-ahead at the new line.
`timescale 1ns/1ps
`include "fra_map.svh"
module fra_accel (
    input  wire logic                      clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      pref_enable_in,
    input  wire logic                      dcache_enable_in,
    input  wire logic [`FRA_WAIT_W-1:0]    flash_wait_count_in,
    input  wire logic [`FRA_THRESH_W-1:0]  ce_threshold_in,
    input  wire logic                      ce_clear_in,
    input  fra_pkg::fra_req_type           ifetch_req_in,
    output fra_pkg::fra_rsp_type           ifetch_rsp_out,
    input  fra_pkg::fra_req_type           dread_req_in,
    output fra_pkg::fra_rsp_type           dread_rsp_out,
    output fra_pkg::fra_line_type          flash_line_addr_out,
    output logic                           flash_read_out,
    input  fra_pkg::fra_flash_line_type    flash_line_in,
    output logic                           ue_nmi_out,
    output logic                           ce_int_out,
    output logic [`FRA_THRESH_W-1:0]       ce_count_out
);
    import fra_pkg::*;

    fra_state_type st;
    fra_state_type next_st;

    // ------------------------------------------------------------
    // SECDED decode of one 64-bit half
    // ------------------------------------------------------------
    // Code: data bit k sits at the k-th position in 1..71 that is no power of two;
    // check bit i covers positions with bit i set; bit 7 is overall parity.
    function automatic logic [6:0] fra_syn_calc(input logic [`FRA_HALF_W-1:0] d);
        logic [6:0] s;
        int         k;
        s = 7'h00;
        k = 0;
        for (int p = 1; p < `FRA_HALF_W + `FRA_ECC_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                for (int b = 0; b < 7; b++) begin
                    if (((p >> b) & 1) != 0) begin
                        s[b] = s[b] ^ d[k];
                    end
                end
                k++;
            end
        end
        return s;
    endfunction

    // Returns {uncorrectable, corrected, data}
    function automatic logic [`FRA_HALF_W+1:0] fra_secded(
        input logic [`FRA_HALF_W-1:0] d,
        input logic [`FRA_ECC_W-1:0]  e
    );
        logic [6:0]             syn;
        logic                   par;
        logic [`FRA_HALF_W-1:0] fixed;
        logic                   ce;
        logic                   ue;
        int                     pos;
        syn   = fra_syn_calc(d) ^ e[6:0];
        par   = ^{d, e};
        fixed = d;
        ce    = 1'b0;
        ue    = 1'b0;
        pos   = 0;
        if (syn != 7'h00 && par) begin
            ce = 1'b1;
            // Check-bit positions leave the data alone
            for (int p = 1; p < `FRA_HALF_W + `FRA_ECC_W; p++) begin
                if ((p & (p - 1)) != 0) begin
                    if (syn == 7'(p)) begin
                        fixed[pos] = ~d[pos];
                    end
                    pos++;
                end
            end
        end else if (syn == 7'h00 && par) begin
            ce = 1'b1;
        end else if (syn != 7'h00) begin
            ue = 1'b1;
        end
        return {ue, ce, fixed};
    endfunction

    logic [`FRA_HALF_W+1:0] dec_lo;
    logic [`FRA_HALF_W+1:0] dec_hi;
    fra_data_type           clean;
    logic                   any_ce;
    logic                   any_ue;

    always_comb begin
        dec_lo = fra_secded(st.raw[`FRA_HALF_W-1:0], st.raw_ecc[0]); // RL11
        dec_hi = fra_secded(st.raw[`FRA_LINE_W-1:`FRA_HALF_W], st.raw_ecc[1]); // RL11
        clean  = {dec_hi[`FRA_HALF_W-1:0], dec_lo[`FRA_HALF_W-1:0]};
        any_ce = dec_lo[`FRA_HALF_W] | dec_hi[`FRA_HALF_W];
        any_ue = dec_lo[`FRA_HALF_W+1] | dec_hi[`FRA_HALF_W+1];
    end

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    fra_line_type i_line;
    fra_line_type d_line;
    logic [2:0]   i_sel;
    logic [2:0]   d_sel;
    logic         hit0;
    logic         hit1;
    logic         d_hit;

    always_comb begin
        i_line = ifetch_req_in.addr[`FRA_ADDR_W-1:`FRA_WORD_SEL_W];
        d_line = dread_req_in.addr[`FRA_ADDR_W-1:`FRA_WORD_SEL_W];
        i_sel  = ifetch_req_in.addr[`FRA_WORD_SEL_W-1:0];
        d_sel  = dread_req_in.addr[`FRA_WORD_SEL_W-1:0];
        hit0   = pref_enable_in && st.buf_valid[0] && st.buf_line[0] == i_line;
        hit1   = pref_enable_in && st.buf_valid[1] && st.buf_line[1] == i_line;
        d_hit  = dcache_enable_in && st.dc_valid && st.dc_line == d_line;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.i_ready = 1'b0;
        next_st.d_ready = 1'b0;
        if (!pref_enable_in) begin
            next_st.buf_valid = 2'b00; // RL1
        end
        if (!dcache_enable_in) begin
            next_st.dc_valid = 1'b0; // RL7
        end
        if (ce_clear_in) begin
            next_st.ce_count = '0;
            next_st.ce_int   = 1'b0;
        end

        // Zero-wait answers from buffer and cache
        if (ifetch_req_in.valid && !st.i_ready && (hit0 || hit1)) begin
            next_st.i_ready = 1'b1; // RL5
            next_st.i_data  = hit0 ? st.buf_data[0][i_sel*`FRA_WORD_W +: `FRA_WORD_W]
                                   : st.buf_data[1][i_sel*`FRA_WORD_W +: `FRA_WORD_W];
            // Moving onto the younger entry frees the older one for refill
            if (hit1 && st.buf_valid[0] && st.buf_line[0] + 1'b1 == i_line) begin
                next_st.buf_valid[0] = 1'b0; // RL4
            end else if (hit0 && st.buf_valid[1] && st.buf_line[1] + 1'b1 == i_line) begin
                next_st.buf_valid[1] = 1'b0; // RL4
            end
        end
        if (dread_req_in.valid && !st.d_ready && d_hit) begin
            next_st.d_ready = 1'b1; // RL9
            next_st.d_data  = st.dc_data[d_sel*`FRA_WORD_W +: `FRA_WORD_W]; // RL9
        end

        unique case (st.fsm)
            FRA_IDLE: begin
                if (dread_req_in.valid && !st.d_ready && !d_hit) begin
                    next_st.owner      = FRA_OWN_DATA;
                    next_st.fetch_line = d_line;
                    next_st.fsm        = FRA_WAIT;
                    next_st.wait_cnt   = flash_wait_count_in;
                end else if (ifetch_req_in.valid && !st.i_ready && !(hit0 || hit1)) begin
                    next_st.owner      = FRA_OWN_IFETCH;
                    next_st.fetch_line = i_line;
                    next_st.fsm        = FRA_WAIT;
                    next_st.wait_cnt   = flash_wait_count_in;
                    next_st.buf_valid  = 2'b00; // RL15
                    next_st.next_pref  = i_line + 1'b1; // RL2
                end else if (pref_enable_in && ~&next_st.buf_valid) begin
                    next_st.owner      = FRA_OWN_PREF;
                    next_st.fetch_line = st.next_pref; // RL4
                    next_st.buf_slot   = next_st.buf_valid[0] ? 1'b1 : 1'b0;
                    next_st.pref_flush = 1'b0;
                    next_st.fsm        = FRA_WAIT;
                    next_st.wait_cnt   = flash_wait_count_in;
                end
            end
            FRA_WAIT: begin
                // A miss to another line during a prefetch makes that line stale
                if (st.owner == FRA_OWN_PREF && ifetch_req_in.valid
                    && !(hit0 || hit1) && i_line != st.fetch_line) begin
                    next_st.pref_flush = 1'b1; // RL15
                end
                if (st.wait_cnt == '0) begin
                    next_st.raw     = flash_line_in.data;
                    next_st.raw_ecc = flash_line_in.ecc;
                    next_st.fsm     = FRA_CHECK;
                end else begin
                    next_st.wait_cnt = st.wait_cnt - 1'b1; // RL6
                end
            end
            FRA_CHECK: begin
                next_st.fsm   = FRA_IDLE;
                next_st.owner = FRA_OWN_NONE;
                if (any_ue) begin
                    next_st.ue_nmi = 1'b1; // RL13
                end
                if (any_ce && !(&st.ce_count)) begin
                    next_st.ce_count = st.ce_count + 1'b1; // RL14
                end
                if (any_ce && st.ce_count + 1'b1 >= ce_threshold_in) begin
                    next_st.ce_int = 1'b1; // RL14
                end
                unique case (st.owner)
                    FRA_OWN_DATA: begin
                        next_st.d_ready = 1'b1;
                        next_st.d_data  = clean[d_sel*`FRA_WORD_W +: `FRA_WORD_W];
                        if (dcache_enable_in) begin
                            next_st.dc_valid = 1'b1; // RL8
                            next_st.dc_line  = st.fetch_line; // RL10
                            next_st.dc_data  = clean; // RL12
                        end
                    end
                    FRA_OWN_IFETCH: begin
                        next_st.i_ready = 1'b1;
                        next_st.i_data  = clean[i_sel*`FRA_WORD_W +: `FRA_WORD_W];
                        if (pref_enable_in) begin
                            next_st.buf_valid[0] = 1'b1; // RL3
                            next_st.buf_line[0]  = st.fetch_line;
                            next_st.buf_data[0]  = clean; // RL12
                        end
                    end
                    FRA_OWN_PREF: begin
                        if (pref_enable_in && !st.pref_flush) begin
                            next_st.buf_valid[st.buf_slot] = 1'b1; // RL3
                            next_st.buf_line[st.buf_slot]  = st.fetch_line;
                            next_st.buf_data[st.buf_slot]  = clean; // RL12
                            next_st.next_pref = st.fetch_line + 1'b1; // RL2
                        end
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                next_st.fsm = FRA_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign ifetch_rsp_out      = '{ready: st.i_ready, data: st.i_data};
    assign dread_rsp_out       = '{ready: st.d_ready, data: st.d_data};
    assign flash_line_addr_out = st.fetch_line;
    assign flash_read_out      = (st.fsm == FRA_WAIT);
    assign ue_nmi_out          = st.ue_nmi; // RL13
    assign ce_int_out          = st.ce_int; // RL14
    assign ce_count_out        = st.ce_count;
endmodule

// [verilog/fra_map.svh]
// Purpose: Constants of the flash read accelerator
// Assumes: 100 MHz clock; 16-bit CPU words; 128-bit flash lines
// Notes:   Widths and reset values only; types live in fra_pkg
`ifndef FRA_MAP_SVH
`define FRA_MAP_SVH
`define FRA_ADDR_W        22
`define FRA_LINE_W        128
`define FRA_HALF_W        64
`define FRA_ECC_W         8
`define FRA_WORD_W        16
`define FRA_WORD_SEL_W    3
`define FRA_WAIT_W        4
`define FRA_THRESH_W      16
`define FRA_WAIT_RESET    4'h0
`define FRA_THRESH_RESET  16'h0001
`endif

// [verilog/fra_pkg.sv]
// Purpose: Types of the flash read accelerator
// Assumes: fra_map.svh gives all widths
// Notes:   Line index is the word address with the low three bits dropped
`include "fra_map.svh"
package fra_pkg;
    typedef logic [`FRA_ADDR_W-1:0]                    fra_addr_type;
    typedef logic [`FRA_ADDR_W-`FRA_WORD_SEL_W-1:0]    fra_line_type;
    typedef logic [`FRA_LINE_W-1:0]                    fra_data_type;
    typedef logic [`FRA_WORD_W-1:0]                    fra_word_type;

    typedef enum logic [1:0] {
        FRA_IDLE  = 2'b00,
        FRA_WAIT  = 2'b01,
        FRA_CHECK = 2'b10
    } fra_flash_state_type;

    typedef enum logic [1:0] {
        FRA_OWN_NONE  = 2'b00,
        FRA_OWN_IFETCH = 2'b01,
        FRA_OWN_PREF  = 2'b10,
        FRA_OWN_DATA  = 2'b11
    } fra_owner_type;

    // CPU request group
    typedef struct packed {
        logic         valid;
        fra_addr_type addr;
    } fra_req_type;

    // CPU answer group
    typedef struct packed {
        logic         ready;
        fra_word_type data;
    } fra_rsp_type;

    // Flash line with two ECC bytes, one per 64-bit half
    typedef struct packed {
        logic [1:0][`FRA_ECC_W-1:0] ecc;
        fra_data_type               data;
    } fra_flash_line_type;

    typedef struct packed {
        fra_flash_state_type      fsm;
        fra_owner_type            owner;
        logic [`FRA_WAIT_W-1:0]   wait_cnt;
        fra_line_type             fetch_line;
        logic [1:0]               buf_valid;
        fra_line_type [1:0]       buf_line;
        fra_data_type [1:0]       buf_data;
        logic                     buf_slot;
        fra_line_type             next_pref;
        logic                     pref_flush;
        logic                     dc_valid;
        fra_line_type             dc_line;
        fra_data_type             dc_data;
        fra_data_type             raw;
        logic [1:0][`FRA_ECC_W-1:0] raw_ecc;
        logic                     i_ready;
        fra_word_type             i_data;
        logic                     d_ready;
        fra_word_type             d_data;
        logic [`FRA_THRESH_W-1:0] ce_count;
        logic                     ue_nmi;
        logic                     ce_int;
    } fra_state_type;
endpackage
